/* awk_pkg.sv */
//==========================================================
// Function
// - readable mirror of each port queue control
// - no wake output while master enable clear
// - master enable cleared only by standby reset
// - pending flag sets regardless of master enable
// - write one clears pending, zero ignored
// - pending flag cleared only by standby reset
// - per-source flags set on each source event
// - write one clears source flag bits
// - source flags cleared only by standby reset
// - wake asserted when source enabled and master
// - disabled source still recorded, no wake
// - source enables cleared only by standby reset
// - select picks request-to-send or address bit 12
// - select picks clear-to-send or address bit 13
// - select picks terminal-ready or address bit 14
package awk_pkg;
    //==========================================================
    // register offsets
    localparam logic [7:0] OFS_PORT1_MIRROR = 8'hc3;
    localparam logic [7:0] OFS_PORT2_MIRROR = 8'hc4;
    localparam logic [7:0] OFS_MASTER_CTRL  = 8'hc5;
    localparam logic [7:0] OFS_PENDING      = 8'hc6;
    localparam logic [7:0] OFS_SRC_FLAGS    = 8'hc7;
    localparam logic [7:0] OFS_SRC_ENABLES  = 8'hc8;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'hd0;
    localparam logic [7:0] OFS_IRQ_MASK     = 8'hd1;
    localparam logic [7:0] OFS_PIN_MUX      = 8'hd2;
    //==========================================================
    // fields
    localparam int         BIT_MASTER_EN  = 0;
    localparam int         BIT_PENDING    = 0;
    localparam int         BIT_ADDR_QUAL  = 0;
    localparam logic [7:0] SRC_MASK       = 8'h1e;
    localparam logic [7:0] MIRROR_MASK    = 8'hcf;
    localparam logic [1:0] IRQ_MASK_BITS  = 2'h3;
    //==========================================================
    // reset values
    localparam logic [7:0] RST_REG        = 8'h00;
    localparam logic [1:0] RST_IRQ        = 2'h0;
endpackage

/* awk_regs.sv */
// Decided for this implementation: the address-and-strobe port.
module awk_regs (
    // clock and resets
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       standby_power_on_reset_n,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // snooped serial port queue control writes
    input  wire logic       port1_queue_ctrl_wr,
    input  wire logic       port2_queue_ctrl_wr,
    input  wire logic [7:0] queue_ctrl_data,
    // wake sources, one-cycle pulses: bit1 port2 ring, bit2 port1 ring, bit3 keyboard, bit4 mouse
    input  wire logic [7:0] wake_events,
    // wake and interrupt outputs
    output logic            wake_out_n,
    output logic            irq,
    // port 2 pins
    input  wire logic       port2_rts_int_n,
    input  wire logic       port2_dtr_int_n,
    input  wire logic       port2_cts_pin_n,
    output logic            port2_request_to_send_n,
    output logic            port2_request_to_send_oe_n,
    input  wire logic       port2_request_to_send_in,
    output logic            port2_terminal_ready_n,
    output logic            port2_terminal_ready_oe_n,
    input  wire logic       port2_terminal_ready_in,
    output logic            port2_clear_to_send_n,
    output logic      [2:0] sa_high
);
    //==========================================================
    // reset synchronisers
    // both resets assert at once and release through two flops
    // the wake registers follow only the standby copy, so a main reset cannot touch them
    logic       rst_sync_n;
    logic       sb_sync_n;

    awk_rst_sync u_main_sync (
        .clk    (clk),
        .arst_n (rstn),
        .srst_n (rst_sync_n)
    );

    awk_rst_sync u_standby_sync (
        .clk    (clk),
        .arst_n (standby_power_on_reset_n),
        .srst_n (sb_sync_n)
    );

    //==========================================================
    // write decode
    // the mirror offsets get no write strobe: a host write there changes nothing
    // one strobe at most per cycle; unmapped writes fall through
    logic       wr_master;
    logic       wr_pend;
    logic       wr_flags;
    logic       wr_en;
    logic       wr_istat;
    logic       wr_imask;
    logic       wr_mux;

    always_comb begin
        wr_master = 1'b0;
        wr_pend   = 1'b0;
        wr_flags  = 1'b0;
        wr_en     = 1'b0;
        wr_istat  = 1'b0;
        wr_imask  = 1'b0;
        wr_mux    = 1'b0;
        if (wr) begin
            if (addr == awk_pkg::OFS_MASTER_CTRL) begin
                wr_master = 1'b1;
            end else if (addr == awk_pkg::OFS_PENDING) begin
                wr_pend = 1'b1;
            end else if (addr == awk_pkg::OFS_SRC_FLAGS) begin
                wr_flags = 1'b1;
            end else if (addr == awk_pkg::OFS_SRC_ENABLES) begin
                wr_en = 1'b1;
            end else if (addr == awk_pkg::OFS_IRQ_STATUS) begin
                wr_istat = 1'b1;
            end else if (addr == awk_pkg::OFS_IRQ_MASK) begin
                wr_imask = 1'b1;
            end else if (addr == awk_pkg::OFS_PIN_MUX) begin
                wr_mux = 1'b1;
            end
        end
    end

    //==========================================================
    // queue control mirrors
    // reserved bits 5:4 are dropped on capture so they always read 0
    // the mirrors sit on the main reset: a main reset forgets them
    logic [7:0] mirror1;
    logic [7:0] mirror2;

    awk_mirror #(
        .KEEP_MASK (awk_pkg::MIRROR_MASK)
    ) u_mirror1 (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .load  (port1_queue_ctrl_wr),
        .din   (queue_ctrl_data),
        .dout  (mirror1)
    );

    awk_mirror #(
        .KEEP_MASK (awk_pkg::MIRROR_MASK)
    ) u_mirror2 (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .load  (port2_queue_ctrl_wr),
        .din   (queue_ctrl_data),
        .dout  (mirror2)
    );

    //==========================================================
    // wake source events
    // only the four source bits count; other event bits are ignored
    // events are one-cycle pulses; a level held high would set a flag every cycle
    logic [7:0] src_ev;
    logic       wake_cond;
    logic       master_en;
    logic [7:0] enables;
    logic       pending;
    logic [7:0] flags;

    assign src_ev    = wake_events & awk_pkg::SRC_MASK;
    assign wake_cond = |(src_ev & enables);

    //==========================================================
    // wake enables, standby domain
    // these survive every reset except the standby one
    always_ff @(posedge clk or negedge sb_sync_n) begin
        if (!sb_sync_n) begin
            master_en <= 1'b0;
        end else if (wr_master) begin
            master_en <= wdata[awk_pkg::BIT_MASTER_EN];
        end
    end

    always_ff @(posedge clk or negedge sb_sync_n) begin
        if (!sb_sync_n) begin
            enables <= awk_pkg::RST_REG;
        end else if (wr_en) begin
            enables <= wdata & awk_pkg::SRC_MASK;
        end
    end

    //==========================================================
    // wake status, standby domain
    // pending only counts enabled sources; the master enable gates the pin alone
    awk_sticky #(
        .WIDTH (1),
        .KEEP  (1'b1)
    ) u_pending (
        .clk      (clk),
        .rst_n    (sb_sync_n),
        .set_bits (wake_cond),
        .clr_wr   (wr_pend),
        .clr_bits (wdata[awk_pkg::BIT_PENDING]),
        .flags    (pending)
    );

    // flags record every source whatever the enables say
    awk_sticky #(
        .WIDTH (8),
        .KEEP  (awk_pkg::SRC_MASK)
    ) u_flags (
        .clk      (clk),
        .rst_n    (sb_sync_n),
        .set_bits (src_ev),
        .clr_wr   (wr_flags),
        .clr_bits (wdata),
        .flags    (flags)
    );

    // open-drain style active-low wake, gated by master enable
    // the pending flag keeps recording with the master enable off, but the pin stays quiet
    assign wake_out_n = !(pending && master_en);

    //==========================================================
    // interrupt: bit0 enabled-source event, bit1 any source event
    logic [1:0] iev;
    logic [1:0] istat;
    logic [1:0] imask;

    assign iev = {|src_ev, wake_cond};

    awk_sticky #(
        .WIDTH (2),
        .KEEP  (awk_pkg::IRQ_MASK_BITS)
    ) u_istat (
        .clk      (clk),
        .rst_n    (rst_sync_n),
        .set_bits (iev),
        .clr_wr   (wr_istat),
        .clr_bits (wdata[1:0]),
        .flags    (istat)
    );

    // mask: same layout as the status bits
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            imask <= awk_pkg::RST_IRQ;
        end else if (wr_imask) begin
            imask <= wdata[1:0] & awk_pkg::IRQ_MASK_BITS;
        end
    end

    // level output: high while any unmasked status bit stands
    assign irq = |(istat & imask);

    //==========================================================
    // pin multiplexing
    // the select sits on the main reset, so the pins return to modem use after any main reset
    logic addr_qual_select;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            addr_qual_select <= 1'b0;
        end else if (wr_mux) begin
            addr_qual_select <= wdata[awk_pkg::BIT_ADDR_QUAL];
        end
    end

    always_comb begin
        port2_request_to_send_n = port2_rts_int_n;
        port2_terminal_ready_n  = port2_dtr_int_n;
        if (addr_qual_select) begin
            // address mode: outputs released, the host drives the pins; an open rts or dtr pin reads 0, an open cts pin reads 1
            port2_request_to_send_oe_n = 1'b1;
            port2_terminal_ready_oe_n  = 1'b1;
            port2_clear_to_send_n      = 1'b1;
            sa_high = {port2_terminal_ready_in, port2_cts_pin_n, port2_request_to_send_in};
        end else begin
            // modem mode: outputs driven, clear-to-send passed through
            port2_request_to_send_oe_n = 1'b0;
            port2_terminal_ready_oe_n  = 1'b0;
            port2_clear_to_send_n      = port2_cts_pin_n;
            sa_high                    = 3'h0;
        end
    end

    //==========================================================
    // read data, one cycle after the strobe
    // idle cycles return 0 so a stray sample never shows old data
    // unmapped offsets read 0 as well
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (rd) begin
            if (addr == awk_pkg::OFS_PORT1_MIRROR) begin
                next_rdata = mirror1;
            end else if (addr == awk_pkg::OFS_PORT2_MIRROR) begin
                next_rdata = mirror2;
            end else if (addr == awk_pkg::OFS_MASTER_CTRL) begin
                next_rdata = {7'h00, master_en};
            end else if (addr == awk_pkg::OFS_PENDING) begin
                next_rdata = {7'h00, pending};
            end else if (addr == awk_pkg::OFS_SRC_FLAGS) begin
                next_rdata = flags;
            end else if (addr == awk_pkg::OFS_SRC_ENABLES) begin
                next_rdata = enables;
            end else if (addr == awk_pkg::OFS_IRQ_STATUS) begin
                next_rdata = {6'h00, istat};
            end else if (addr == awk_pkg::OFS_IRQ_MASK) begin
                next_rdata = {6'h00, imask};
            end else if (addr == awk_pkg::OFS_PIN_MUX) begin
                next_rdata = {7'h00, addr_qual_select};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule // awk_regs

//==========================================================
// two-flop reset release
// assertion passes straight through; only the release waits for the clock
// one instance per reset domain
module awk_rst_sync (
    // clock
    input  wire logic clk,
    // asynchronous reset in
    input  wire logic arst_n,
    // reset released on the clock
    output logic      srst_n
);
    logic stage1;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= 1'b0;
            srst_n <= 1'b0;
        end else begin
            stage1 <= 1'b1;
            srst_n <= stage1;
        end
    end
endmodule // awk_rst_sync

//==========================================================
// write-only register mirror
// captures every snooped write; the host path has no way in
module awk_mirror #(
    parameter logic [7:0] KEEP_MASK = 8'hff
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // snooped write
    input  wire logic       load,
    input  wire logic [7:0] din,
    // readable copy
    output logic      [7:0] dout
);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= awk_pkg::RST_REG;
        end else if (load) begin
            dout <= din & KEEP_MASK;
        end
    end
endmodule // awk_mirror

//==========================================================
// sticky flags, write one to clear
// set wins over a clear in the same cycle, so an event is never lost
// keep clears reserved bits so they always read 0
module awk_sticky #(
    parameter int               WIDTH = 8,
    parameter logic [WIDTH-1:0] KEEP  = '1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // events
    input  wire logic [WIDTH-1:0] set_bits,
    // software clear
    input  wire logic             clr_wr,
    input  wire logic [WIDTH-1:0] clr_bits,
    // status
    output logic      [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] next_flags;

    always_comb begin
        next_flags = flags;
        if (clr_wr) begin
            next_flags = flags & ~clr_bits;
        end
        next_flags = (next_flags | set_bits) & KEEP;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end
endmodule // awk_sticky

/* awk_pins.sv */
// ==========
// far side: serial pins and host address lines
module awk_pins (
    input  wire logic       rts_n, rts_oe_n, dtr_n, dtr_oe_n, host_en,
    input  wire logic [2:0] host_sa,
    output logic            rts_pin, dtr_pin, cts_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released address line reads 0 and an idle modem input reads 1, so stale values never hide a fault
    assign rts_pin = !rts_oe_n ? rts_n : host_en & host_sa[0];
    assign cts_pin = host_en ? host_sa[1] : 1'h1;
    assign dtr_pin = !dtr_oe_n ? dtr_n : host_en & host_sa[2];
endmodule // awk_pins

/* awk_regs_properties.sv */
// ==========
// checker
module awk_props (
    input wire logic       clk, rstn, standby_power_on_reset_n, wr, rd, wake_out_n,
    input wire logic [7:0] addr, wdata, rdata, wake_events, queue_ctrl_data,
    input wire logic       port1_queue_ctrl_wr, port2_rts_int_n, port2_dtr_int_n, port2_cts_pin_n,
    input wire logic       port2_request_to_send_n, port2_request_to_send_oe_n, port2_request_to_send_in,
    input wire logic       port2_terminal_ready_n, port2_terminal_ready_oe_n, port2_terminal_ready_in,
    input wire logic       port2_clear_to_send_n,
    input wire logic [2:0] sa_high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       men, sel;
    logic [7:0] ena;
    // shadow copies of the enables, tracked from the register port writes
    always_ff @(posedge clk or negedge standby_power_on_reset_n)
        if (!standby_power_on_reset_n) {men, ena} <= 9'h000;
        else if (wr && addr == 8'hc5) men <= wdata[0];
        else if (wr && addr == 8'hc8) ena <= wdata & 8'h1e;
    always_ff @(posedge clk or negedge rstn)
        if (!rstn) sel <= 1'h0;
        else if (wr && addr == 8'hd2) sel <= wdata[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || !standby_power_on_reset_n);
    sequence s_snoop_read; port1_queue_ctrl_wr ##1 (rd && addr == 8'hc3 && !port1_queue_ctrl_wr); endsequence
    sequence s_key_read; wake_events[3] ##1 (rd && addr == 8'hc7 && !wake_events[3]); endsequence
    property p_mirror; s_snoop_read |=> rdata == ($past(queue_ctrl_data, 2) & 8'hcf); endproperty
    property p_flag; s_key_read |=> rdata[3]; endproperty
    property p_no_wake; !men |-> wake_out_n; endproperty
    property p_wake_on; men && !wr && (wake_events & ena) != 8'h00 |=> !wake_out_n; endproperty
    property p_clear; wr && addr == 8'hc6 && wdata[0] && wake_events == 8'h00 |=> wake_out_n; endproperty
    property p_rts; port2_request_to_send_oe_n == sel && (sel || port2_request_to_send_n == port2_rts_int_n); endproperty
    property p_dtr; port2_terminal_ready_oe_n == sel && (sel || port2_terminal_ready_n == port2_dtr_int_n); endproperty
    property p_cts;
        port2_clear_to_send_n == (sel | port2_cts_pin_n) && sa_high ==
            (sel ? {port2_terminal_ready_in, port2_cts_pin_n, port2_request_to_send_in} : 3'h0);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror read wrong");
    a_flag: assert property (p_flag) else $error("source flag not set");
    a_no_wake: assert property (p_no_wake) else $error("wake while master off");
    a_wake_on: assert property (p_wake_on) else $error("wake missing");
    a_clear: assert property (p_clear) else $error("wake not released");
    a_rts: assert property (p_rts) else $error("rts mux wrong");
    a_dtr: assert property (p_dtr) else $error("dtr mux wrong");
    a_cts: assert property (p_cts) else $error("cts mux wrong");
endmodule // awk_props
bind awk_regs awk_props u_props (
    .clk                        (clk),
    .rstn                       (rstn),
    .standby_power_on_reset_n   (standby_power_on_reset_n),
    .wr                         (wr),
    .rd                         (rd),
    .wake_out_n                 (wake_out_n),
    .addr                       (addr),
    .wdata                      (wdata),
    .rdata                      (rdata),
    .wake_events                (wake_events),
    .queue_ctrl_data            (queue_ctrl_data),
    .port1_queue_ctrl_wr        (port1_queue_ctrl_wr),
    .port2_rts_int_n            (port2_rts_int_n),
    .port2_dtr_int_n            (port2_dtr_int_n),
    .port2_cts_pin_n            (port2_cts_pin_n),
    .port2_request_to_send_n    (port2_request_to_send_n),
    .port2_request_to_send_oe_n (port2_request_to_send_oe_n),
    .port2_request_to_send_in   (port2_request_to_send_in),
    .port2_terminal_ready_n     (port2_terminal_ready_n),
    .port2_terminal_ready_oe_n  (port2_terminal_ready_oe_n),
    .port2_terminal_ready_in    (port2_terminal_ready_in),
    .port2_clear_to_send_n      (port2_clear_to_send_n),
    .sa_high                    (sa_high)
);

/* awk_regs_tb.sv */
// ==========
// testbench
module awk_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rstn, stby_n, wr, rd, p1w, p2w, rts_i, dtr_i, hen, s, wo_n, irq;
    logic        rts_n, rts_oe_n, dtr_n, dtr_oe_n, cts_o, rts_p, dtr_p, cts_p;
    logic [7:0]  addr, wdata, qd, ev, rdata, d, e;
    logic [2:0]  hsa, sa;
    logic [31:0] seed = 32'h1b;
    int          failures, check_count;
    awk_regs dut (.clk(clk), .rstn(rstn), .standby_power_on_reset_n(stby_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .port1_queue_ctrl_wr(p1w), .port2_queue_ctrl_wr(p2w),
        .queue_ctrl_data(qd), .wake_events(ev), .wake_out_n(wo_n), .irq(irq), .port2_rts_int_n(rts_i),
        .port2_dtr_int_n(dtr_i), .port2_cts_pin_n(cts_p), .port2_request_to_send_n(rts_n),
        .port2_request_to_send_oe_n(rts_oe_n), .port2_request_to_send_in(rts_p), .port2_terminal_ready_n(dtr_n),
        .port2_terminal_ready_oe_n(dtr_oe_n), .port2_terminal_ready_in(dtr_p), .port2_clear_to_send_n(cts_o),
        .sa_high(sa));
    awk_pins u_far (.rts_n(rts_n), .rts_oe_n(rts_oe_n), .dtr_n(dtr_n), .dtr_oe_n(dtr_oe_n), .host_en(hen),
        .host_sa(hsa), .rts_pin(rts_p), .dtr_pin(dtr_p), .cts_pin(cts_p));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] pins(input logic sl, input logic [7:0] v);
        return sl ? {5'h1f, v[4:2]} : {3'h1, v[1:0], 3'h0};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask
    // every bus cycle also ends any pulse launched just before it
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        {wr, rd, addr, wdata, p1w, p2w, ev} <= {w, !w, a, v, 10'h000};
        @(posedge clk);
        {wr, rd} <= 2'h0;
        #1;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] x);
        bus(1'h0, a, 8'h00);
        chk(rdata, x);
    endtask
    task automatic pulse(input logic a, input logic b, input logic [7:0] v, input logic [7:0] x);
        @(posedge clk);
        {p1w, p2w, qd, ev} <= {a, b, v, x};
    endtask
    task automatic reset_pulse(input logic main);
        @(posedge clk);
        {rstn, stby_n} <= main ? 2'h1 : 2'h2;
        repeat (2) @(posedge clk);
        {rstn, stby_n} <= 2'h3;
        repeat (3) @(posedge clk);
    endtask
    task automatic finish_test();
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        finish_test();
    end
    initial begin
        {rstn, stby_n, wr, rd, p1w, p2w, hen, rts_i, dtr_i, hsa} <= 12'h000;
        {addr, wdata, qd, ev} <= 32'h0;
        repeat (16) @(posedge clk);
        {rstn, stby_n} <= 2'h3;
        repeat (3) @(posedge clk);
        for (logic [7:0] a = 8'hc5; a < 8'hc9; a++) rc(a, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'(rnd());
            pulse(i[0], !i[0], d, 8'h00);
            rc(i[0] ? 8'hc3 : 8'hc4, d & 8'hcf);
        end
        bus(1'h1, 8'hc3, ~d);
        rc(8'hc3, d & 8'hcf);
        rc(8'h00, 8'h00);
        bus(1'h1, 8'hc8, 8'h1e);
        d = 8'(rnd());
        e = 8'h02 << d[1:0];
        pulse(1'h0, 1'h0, 8'h00, e);
        rc(8'hc7, e);
        chk({7'h00, wo_n}, 8'h01);
        rc(8'hc6, 8'h01);
        rc(8'hd0, 8'h03);
        chk({7'h00, irq}, 8'h00);
        bus(1'h1, 8'hd1, 8'h03);
        chk({7'h00, irq}, 8'h01);
        bus(1'h1, 8'hd1, 8'h00);
        bus(1'h1, 8'hd0, 8'h03);
        chk({7'h00, irq}, 8'h00);
        bus(1'h1, 8'hc5, 8'h01);
        bus(1'h1, 8'hc6, 8'h00);
        chk({7'h00, wo_n}, 8'h00);
        bus(1'h1, 8'hc6, 8'h01);
        chk({7'h00, wo_n}, 8'h01);
        bus(1'h1, 8'hc7, e);
        rc(8'hc7, 8'h00);
        bus(1'h1, 8'hc8, 8'h1e & ~e);
        pulse(1'h0, 1'h0, 8'h00, e);
        rc(8'hc7, e);
        chk({7'h00, wo_n}, 8'h01);
        bus(1'h1, 8'hc8, 8'h1e);
        pulse(1'h0, 1'h0, 8'h00, 8'hff);
        rc(8'hc7, 8'h1e);
        chk({7'h00, wo_n}, 8'h00);
        reset_pulse(1'h1);
        rc(8'hc3, 8'h00);
        for (logic [7:0] a = 8'hc5; a < 8'hc9; a++) rc(a, a == 8'hc7 || a == 8'hc8 ? 8'h1e : 8'h01);
        reset_pulse(1'h0);
        for (logic [7:0] a = 8'hc5; a < 8'hc9; a++) rc(a, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'(rnd());
            s = i[1];
            bus(1'h1, 8'hd2, {7'h00, s});
            @(posedge clk);
            {rts_i, dtr_i, hsa, hen} <= {d[1:0], d[4:2], s};
            @(posedge clk);
            #1;
            chk({rts_oe_n, dtr_oe_n, cts_o, rts_n | s, dtr_n | s, sa}, pins(s, d));
        end
        finish_test();
    end
endmodule // awk_regs_tb
